// file: easim_pkg.sv
// Constants shared by the E1 alarm status and interrupt mask block.
`default_nettype none
package easim_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_RX_ALARM_STATUS    = 8'h06;
  localparam logic [7:0] IDX_TIMING_STATUS      = 8'h07;
  localparam logic [7:0] IDX_RX_ALARM_IRQ_MASK  = 8'h16;
  localparam logic [7:0] IDX_TIMING_IRQ_MASK    = 8'h17;
  localparam logic [7:0] IDX_CONTROL            = 8'h1A;
  localparam logic [7:0] IDX_FRAMER_IRQ_SUMMARY = 8'h1B;

  // Receive alarm status fields.
  localparam int B_SIG_ONES    = 7;
  localparam int B_DIST_MF     = 6;
  localparam int B_SIG_ZEROS   = 5;
  localparam int B_RX_SLIP     = 4;
  localparam int B_UNFR_ONES   = 3;
  localparam int B_REMOTE      = 2;
  localparam int B_CARRIER     = 1;
  localparam int B_SYNC_LOST   = 0;
  // Timing event status fields.
  localparam int B_RX_CAS_MF   = 7;
  localparam int B_RX_ALIGN    = 6;
  localparam int B_TX_MF       = 5;
  localparam int B_TIMER       = 4;
  localparam int B_TX_ALIGN    = 3;
  localparam int B_TX_CLK_LOST = 2;
  localparam int B_RX_CRC_MF   = 1;
  localparam int B_TX_SLIP     = 0;
  // Control fields.
  localparam int B_PIN_EN = 0;
  localparam int B_FAST   = 7;

  localparam logic [7:0] STATUS_RST  = 8'h00;
  localparam logic [7:0] MASK_RST    = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;

  // Line timing, in receive bit times.
  localparam logic [7:0] LAST_BIT_OF_FRAME = 8'hFF;
  localparam logic [3:0] LAST_FRAME_OF_MF  = 4'hF;
  localparam logic [4:0] TS16_SLOT         = 5'h10;
  localparam logic [7:0] DMA_BIT_POS       = 8'h85;
  localparam logic [7:0] RRA_BIT_POS       = 8'h02;
  localparam logic [7:0] TS16_BITS_PER_MF  = 8'h80;
  localparam logic [7:0] SA1_MIN_ZEROS     = 8'h03;
  localparam logic [8:0] UA1_WINDOW_LAST   = 9'h1FF;
  localparam logic [1:0] UA1_MIN_ZEROS     = 2'h3;
  localparam logic [7:0] RCL_ZERO_RUN      = 8'hFF;
  localparam logic [7:0] RCL_WINDOW_LAST   = 8'hFE;
  localparam logic [5:0] RCL_MIN_ONES      = 6'h20;
  localparam logic [3:0] CHANNEL_BITS      = 4'h8;

  // Timer periods as printed, and their lengths in receive bits.
  localparam int RX_BIT_RATE_HZ = 2048000;
  localparam int SEC_PERIOD_MS  = 1000;
  localparam int FAST_PERIOD_US = 62500;
  localparam int SEC_BITS  = RX_BIT_RATE_HZ / 1000 * SEC_PERIOD_MS;
  localparam int FAST_BITS = RX_BIT_RATE_HZ / 1000 * FAST_PERIOD_US / 1000;
endpackage
`default_nettype wire

// file: easim_top.sv
// One E1 framer's receive alarm detectors, latched status and masks.
//
// Behaviour
// - Signaling all ones raised below three TS16 zeros per multiframe.
// - Signaling all ones cleared at three or more zeros per multiframe.
// - Signaling alarms stay active and reported in common channel mode.
// - Distant multiframe alarm raised after bit 6 is one twice running.
// - Distant multiframe alarm cleared after bit 6 is zero twice running.
// - Signaling all zeros raised for an all-zero timeslot 16 multiframe.
// - Signaling all zeros cleared when a one appears in a multiframe.
// - Elastic store repeat or delete sets the matching slip flag.
// - Unframed ones alarm follows zero count in each 512-bit window.
// - Remote alarm follows three equal non-align bit 3 values.
// - Carrier loss raised after 255 consecutive zeros.
// - Carrier loss cleared when 32 ones arrive within 255 bits.
// - Loss of sync flag held set while the framer is unsynchronized.
// - Receive CAS multiframe flag set at each receive multiframe boundary.
// - Receive and transmit align frame flags set at align frame starts.
// - Transmit multiframe flag set at each transmit multiframe boundary.
// - Timer flag set each second, or each 62.5 ms when fast.
// - Transmit clock lost after no transition for one channel time.
// - Loss pin driven high while lost, when the pin is enabled.
// - CRC4 multiframe flag follows CRC4 boundaries, else every multiframe.
// - A mask bit of one lets its status bit reach the interrupt.
// - Unmasked interrupts of all framers drive one active-low output.
// - Per framer and status register interrupt activity is readable.
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module easim_top
  import easim_pkg::*;
#(
  parameter int SEC_PERIOD_BITS  = SEC_BITS,
  parameter int FAST_PERIOD_BITS = FAST_BITS
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        rx_line_clock,
  input  wire logic        rx_positive_data,
  input  wire logic        rx_negative_data,
  input  wire logic        transmit_line_clock,
  input  wire logic        rx_in_sync,
  input  wire logic        rx_mf_start,
  input  wire logic        rx_slip_event,
  input  wire logic        tx_slip_event,
  input  wire logic        tx_mf_boundary,
  input  wire logic        tx_align_frame_start,
  input  wire logic        crc4_enable,
  input  wire logic        rx_crc_mf_boundary,
  input  wire logic [5:0]  peer_irq_active,
  output logic             tx_clock_lost_pin,
  output logic [1:0]       framer_irq_active,
  output logic             int_n
);

  // True when the address falls on the given register's word.
  function automatic logic hits(input logic [31:0] a, input logic [7:0] i);
    hits = (a[31:10] == 22'h0) && (a[9:2] == i) && (a[1:0] == 2'h0);
  endfunction

  // Pin synchronisers: rx clock, rx positive, rx negative, tx clock.
  logic [3:0] pin_raw;
  logic [3:0] meta_reg;
  logic [3:0] sync_reg;
  logic [3:0] last_reg;
  assign pin_raw = {transmit_line_clock, rx_negative_data,
                    rx_positive_data, rx_line_clock};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          meta_reg[g] <= 1'b0;
          sync_reg[g] <= 1'b0;
          last_reg[g] <= 1'b0;
        end else begin
          meta_reg[g] <= pin_raw[g];
          sync_reg[g] <= meta_reg[g];
          last_reg[g] <= sync_reg[g];
        end
      end
    end
  endgenerate

  // Data is taken on the falling edge of the recovered clock, mid-bit.
  wire bit_stb = last_reg[0] & ~sync_reg[0];
  wire mark    = sync_reg[1] | sync_reg[2];
  wire tx_edge = last_reg[3] ^ sync_reg[3];

  // Frame and multiframe position.
  logic [7:0] bit_reg;
  logic [3:0] frm_reg;
  wire frame_end = bit_stb && (bit_reg == LAST_BIT_OF_FRAME);
  wire mf_end    = frame_end && (frm_reg == LAST_FRAME_OF_MF);
  wire in_ts16   = bit_reg[7:3] == TS16_SLOT;
  wire align_beg = bit_stb && (bit_reg == 8'h00) && !frm_reg[0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_reg <= 8'h00;
      frm_reg <= 4'h0;
    end else if (rx_mf_start) begin
      bit_reg <= 8'h00;
      frm_reg <= 4'h0;
    end else if (bit_stb) begin
      bit_reg <= bit_reg + 8'h01;
      if (frame_end) begin
        frm_reg <= frm_reg + 4'h1;
      end
    end
  end

  // Timeslot 16 zero count over each multiframe; never gated by mode.
  logic [7:0] ts16_zeros_reg;
  logic       sa1_reg;
  logic       sa0_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ts16_zeros_reg <= 8'h00;
      sa1_reg        <= 1'b0;
      sa0_reg        <= 1'b0;
    end else if (mf_end) begin
      ts16_zeros_reg <= 8'h00;
      sa1_reg <= ts16_zeros_reg < SA1_MIN_ZEROS;
      sa0_reg <= ts16_zeros_reg == TS16_BITS_PER_MF;
    end else if (bit_stb && in_ts16 && !mark) begin
      ts16_zeros_reg <= ts16_zeros_reg + 8'h01;
    end
  end

  // Distant multiframe and remote alarm bit histories.
  logic [1:0] dma_hist_reg;
  logic [2:0] rra_hist_reg;
  logic       dma_reg;
  logic       rra_reg;
  wire dma_bit = bit_stb && (frm_reg == 4'h0) && (bit_reg == DMA_BIT_POS);
  wire rra_bit = bit_stb && frm_reg[0] && (bit_reg == RRA_BIT_POS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dma_hist_reg <= 2'h0;
      rra_hist_reg <= 3'h0;
    end else begin
      if (dma_bit) begin
        dma_hist_reg <= {dma_hist_reg[0], mark};
      end
      if (rra_bit) begin
        rra_hist_reg <= {rra_hist_reg[1:0], mark};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dma_reg <= 1'b0;
      rra_reg <= 1'b0;
    end else begin
      if (dma_hist_reg == 2'h3) begin
        dma_reg <= 1'b1;
      end else if (dma_hist_reg == 2'h0) begin
        dma_reg <= 1'b0;
      end
      if (rra_hist_reg == 3'h7) begin
        rra_reg <= 1'b1;
      end else if (rra_hist_reg == 3'h0) begin
        rra_reg <= 1'b0;
      end
    end
  end

  // Unframed all ones: zeros counted in fixed 512-bit windows.
  logic [8:0] ua_pos_reg;
  logic [1:0] ua_zeros_reg;
  logic       ua1_reg;
  wire [1:0] ua_zeros_now = (!mark && ua_zeros_reg != UA1_MIN_ZEROS)
                            ? ua_zeros_reg + 2'h1 : ua_zeros_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ua_pos_reg   <= 9'h000;
      ua_zeros_reg <= 2'h0;
      ua1_reg      <= 1'b0;
    end else if (bit_stb) begin
      ua_pos_reg <= ua_pos_reg + 9'h001;
      if (ua_pos_reg == UA1_WINDOW_LAST) begin
        ua_zeros_reg <= 2'h0;
        ua1_reg      <= ua_zeros_now != UA1_MIN_ZEROS;
      end else begin
        ua_zeros_reg <= ua_zeros_now;
      end
    end
  end

  // Carrier loss: a zero run raises it, ones in a window clear it.
  logic [7:0] zero_run_reg;
  logic [7:0] rcl_pos_reg;
  logic [5:0] rcl_ones_reg;
  logic       rcl_reg;
  wire [7:0] zero_run_next = mark ? 8'h00 :
    (zero_run_reg == RCL_ZERO_RUN) ? zero_run_reg : zero_run_reg + 8'h01;
  wire [5:0] rcl_ones_now = (mark && rcl_ones_reg != RCL_MIN_ONES)
                            ? rcl_ones_reg + 6'h01 : rcl_ones_reg;
  wire rcl_win_end = rcl_pos_reg == RCL_WINDOW_LAST;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zero_run_reg <= 8'h00;
      rcl_pos_reg  <= 8'h00;
      rcl_ones_reg <= 6'h00;
      rcl_reg      <= 1'b0;
    end else if (bit_stb) begin
      zero_run_reg <= zero_run_next;
      rcl_pos_reg  <= rcl_win_end ? 8'h00 : rcl_pos_reg + 8'h01;
      rcl_ones_reg <= rcl_win_end ? 6'h00 : rcl_ones_now;
      if (zero_run_next == RCL_ZERO_RUN) begin
        rcl_reg <= 1'b1;
      end else if (rcl_win_end && rcl_ones_now == RCL_MIN_ONES) begin
        rcl_reg <= 1'b0;
      end
    end
  end

  // Transmit clock watchdog, timed in receive bit periods.
  logic [3:0] tx_clock_lost_cnt_reg;
  wire tx_clock_lost_now = tx_clock_lost_cnt_reg == CHANNEL_BITS;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_clock_lost_cnt_reg <= 4'h0;
    end else if (tx_edge) begin
      tx_clock_lost_cnt_reg <= 4'h0;
    end else if (bit_stb && !tx_clock_lost_now) begin
      tx_clock_lost_cnt_reg <= tx_clock_lost_cnt_reg + 4'h1;
    end
  end

  // Registers written by software.
  logic [7:0] mask1_reg;
  logic [7:0] mask2_reg;
  logic [7:0] ctrl_reg;

  // Interval timer on the receive clock.
  logic [20:0] sec_cnt_reg;
  wire [20:0] sec_last = ctrl_reg[B_FAST] ?
    21'(FAST_PERIOD_BITS - 1) : 21'(SEC_PERIOD_BITS - 1);
  wire sec_tick = bit_stb && (sec_cnt_reg >= sec_last);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_cnt_reg <= 21'h000000;
    end else if (sec_tick) begin
      sec_cnt_reg <= 21'h000000;
    end else if (bit_stb) begin
      sec_cnt_reg <= sec_cnt_reg + 21'h000001;
    end
  end

  // Set terms for the two status registers.
  logic [7:0] set1;
  logic [7:0] set2;
  assign set1[B_SIG_ONES]    = sa1_reg;
  assign set1[B_DIST_MF]     = dma_reg;
  assign set1[B_SIG_ZEROS]   = sa0_reg;
  assign set1[B_RX_SLIP]     = rx_slip_event;
  assign set1[B_UNFR_ONES]   = ua1_reg;
  assign set1[B_REMOTE]      = rra_reg;
  assign set1[B_CARRIER]     = rcl_reg;
  assign set1[B_SYNC_LOST]   = !rx_in_sync;
  assign set2[B_RX_CAS_MF]   = mf_end;
  assign set2[B_RX_ALIGN]    = align_beg;
  assign set2[B_TX_MF]       = tx_mf_boundary;
  assign set2[B_TIMER]       = sec_tick;
  assign set2[B_TX_ALIGN]    = tx_align_frame_start;
  assign set2[B_TX_CLK_LOST] = tx_clock_lost_now;
  assign set2[B_RX_CRC_MF]   = crc4_enable ? rx_crc_mf_boundary : mf_end;
  assign set2[B_TX_SLIP]     = tx_slip_event;

  // AHB-Lite slave: zero wait states, always OKAY.
  logic       wr_pend_reg;
  logic [7:0] wr_idx_reg;
  logic [7:0] sr1_reg;
  logic [7:0] sr2_reg;
  logic [31:0] rdata_reg;
  wire addr_ok   = hsel && hready && htrans[1] && (hsize == 3'h2);
  wire wr_sr1    = wr_pend_reg && (wr_idx_reg == IDX_RX_ALARM_STATUS);
  wire wr_sr2    = wr_pend_reg && (wr_idx_reg == IDX_TIMING_STATUS);
  wire [7:0] clr1 = wr_sr1 ? hwdata[7:0] : 8'h00;
  wire [7:0] clr2 = wr_sr2 ? hwdata[7:0] : 8'h00;
  wire [7:0] sr1_next = (sr1_reg & ~clr1) | set1;
  wire [7:0] sr2_next = (sr2_reg & ~clr2) | set2;
  wire act1 = |(sr1_reg & mask1_reg);
  wire act2 = |(sr2_reg & mask2_reg);
  wire [7:0] summary = {peer_irq_active, act2, act1};

  wire [7:0] rmux =
    hits(haddr, IDX_RX_ALARM_STATUS)    ? sr1_reg   :
    hits(haddr, IDX_TIMING_STATUS)      ? sr2_reg   :
    hits(haddr, IDX_RX_ALARM_IRQ_MASK)  ? mask1_reg :
    hits(haddr, IDX_TIMING_IRQ_MASK)    ? mask2_reg :
    hits(haddr, IDX_CONTROL)            ? ctrl_reg  :
    hits(haddr, IDX_FRAMER_IRQ_SUMMARY) ? summary   : 8'h00;

  wire [7:0] map_idx =
    hits(haddr, IDX_RX_ALARM_STATUS)   ? IDX_RX_ALARM_STATUS   :
    hits(haddr, IDX_TIMING_STATUS)     ? IDX_TIMING_STATUS     :
    hits(haddr, IDX_RX_ALARM_IRQ_MASK) ? IDX_RX_ALARM_IRQ_MASK :
    hits(haddr, IDX_TIMING_IRQ_MASK)   ? IDX_TIMING_IRQ_MASK   :
    hits(haddr, IDX_CONTROL)           ? IDX_CONTROL           : 8'h00;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 8'h00;
      rdata_reg   <= 32'h00000000;
    end else begin
      wr_pend_reg <= addr_ok && hwrite;
      wr_idx_reg  <= map_idx;
      if (addr_ok && !hwrite) begin
        rdata_reg <= {24'h000000, rmux};
      end
    end
  end

  // A write never clears an event that arrives in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sr1_reg   <= STATUS_RST;
      sr2_reg   <= STATUS_RST;
      mask1_reg <= MASK_RST;
      mask2_reg <= MASK_RST;
      ctrl_reg  <= CONTROL_RST;
    end else begin
      sr1_reg <= sr1_next;
      sr2_reg <= sr2_next;
      if (wr_pend_reg && wr_idx_reg == IDX_RX_ALARM_IRQ_MASK) begin
        mask1_reg <= hwdata[7:0];
      end
      if (wr_pend_reg && wr_idx_reg == IDX_TIMING_IRQ_MASK) begin
        mask2_reg <= hwdata[7:0];
      end
      if (wr_pend_reg && wr_idx_reg == IDX_CONTROL) begin
        ctrl_reg <= hwdata[7:0];
      end
    end
  end

  // Registered pin outputs.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_clock_lost_pin <= 1'b0;
      framer_irq_active <= 2'h0;
      int_n             <= 1'b1;
    end else begin
      tx_clock_lost_pin <= tx_clock_lost_now && ctrl_reg[B_PIN_EN];
      framer_irq_active <= {act2, act1};
      int_n <= !(act1 || act2 || (|peer_irq_active));
    end
  end

endmodule
`default_nettype wire

// file: easim_line_model.sv
// Behavioural E1 line: recovered receive clock, AMI data, transmit clock.
`timescale 1ns/1ps
`default_nettype none
module easim_line_model (
  input  wire logic ones,
  input  wire logic tx_run,
  output var logic  rx_line_clock,
  output var logic  rx_positive_data,
  output var logic  rx_negative_data,
  output var logic  transmit_line_clock
);
  logic polarity;
  // The odd start offset keeps line edges apart from the bus clock edges.
  initial begin
    polarity = 1'b0;
    rx_line_clock = 1'b0;
    rx_positive_data = 1'b0;
    rx_negative_data = 1'b0;
    transmit_line_clock = 1'b0;
    #7;
    forever #100 rx_line_clock = ~rx_line_clock;
  end
  // Marks alternate polarity; a space leaves both rails low.
  always @(posedge rx_line_clock) begin
    polarity <= polarity ^ ones;
    rx_positive_data <= ones & ~polarity;
    rx_negative_data <= ones & polarity;
  end
  always #100 transmit_line_clock = transmit_line_clock ^ tx_run;
endmodule
`default_nettype wire

// file: easim_props.sv
// Concurrent checks on the bus and interrupt ports of the alarm block.
`timescale 1ns/1ps
`default_nettype none
module easim_props
  import easim_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        rx_slip_event,
  input wire logic        tx_slip_event,
  input wire logic [5:0]  peer_irq_active,
  input wire logic [1:0]  framer_irq_active,
  input wire logic        int_n
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic       rd = hsel && hready && htrans[1] && !hwrite
                        && hsize == 3'h2;
  wire logic [7:0] idx = haddr[9:2];
  wire logic       mapped = idx == IDX_RX_ALARM_STATUS
    || idx == IDX_TIMING_STATUS || idx == IDX_RX_ALARM_IRQ_MASK
    || idx == IDX_TIMING_IRQ_MASK || idx == IDX_CONTROL
    || idx == IDX_FRAMER_IRQ_SUMMARY;
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or answered with an error");
  data_holds_a: assert property (!rd |=> $stable(hrdata))
    else $error("read data changed without a read");
  unmapped_zero_a: assert property (rd && !mapped |=> hrdata == 32'h0)
    else $error("unmapped read returned nonzero data");
  summary_peer_a: assert property (
    rd && idx == IDX_FRAMER_IRQ_SUMMARY
    |=> hrdata[7:2] == $past(peer_irq_active))
    else $error("summary read lost the other framers");
  rx_slip_a: assert property (
    rx_slip_event ##2 (rd && idx == IDX_RX_ALARM_STATUS)
    |=> hrdata[B_RX_SLIP])
    else $error("receive slip not latched");
  tx_slip_a: assert property (
    tx_slip_event ##2 (rd && idx == IDX_TIMING_STATUS)
    |=> hrdata[B_TX_SLIP])
    else $error("transmit slip not latched");
  peer_int_a: assert property ((|peer_irq_active) [*3] |-> !int_n)
    else $error("other framer interrupt not on shared output");
  own_int_a: assert property ((|framer_irq_active) [*2] |-> !int_n)
    else $error("active framer interrupt not on shared output");
  int_cause_a: assert property (
    $fell(int_n) |-> ##[0:1] (|framer_irq_active || |peer_irq_active))
    else $error("interrupt asserted with no cause");
  cover property (rx_slip_event ##2 (rd && idx == IDX_RX_ALARM_STATUS));
  cover property (rd && idx == IDX_FRAMER_IRQ_SUMMARY);
  cover property (framer_irq_active[0] && !int_n);
endmodule
bind easim_top easim_props easim_props_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .rx_slip_event(rx_slip_event), .tx_slip_event(tx_slip_event),
  .peer_irq_active(peer_irq_active),
  .framer_irq_active(framer_irq_active), .int_n(int_n));
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the E1 alarm status and interrupt mask block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import easim_pkg::*;
  typedef struct {
    logic [4:0] ev;
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] msk;
    logic [7:0] exp;
  } easim_row_t;
  // Short timer periods keep the run brief; expectations follow them.
  localparam int SECB  = 64;
  localparam int FASTB = 16;
  localparam int BITC  = 8;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        rx_in_sync = 1'b0;
  logic [4:0]  ev = 5'h00;
  logic [5:0]  peer = 6'h00;
  logic        ones = 1'b1;
  logic        tx_run = 1'b1;
  logic [7:0]  rdv;
  int          fail_count = 0;
  int          checks_done = 0;
  wire logic        hready;
  wire logic        hresp;
  wire logic [31:0] hrdata;
  wire logic        rxc;
  wire logic        rxp;
  wire logic        rxn;
  wire logic        txc;
  wire logic        lost_pin;
  wire logic [1:0]  act;
  wire logic        int_n;
  easim_row_t rows [9] = '{
    '{5'h00, IDX_RX_ALARM_IRQ_MASK, 8'hA5, 8'hFF, 8'hA5},
    '{5'h00, IDX_TIMING_IRQ_MASK, 8'h5A, 8'hFF, 8'h5A},
    '{5'h00, IDX_CONTROL, 8'h81, 8'hFF, 8'h81},
    '{5'h00, 8'h10, 8'hFF, 8'hFF, 8'h00},
    '{5'h10, IDX_RX_ALARM_STATUS, 8'h10, 8'h10, 8'h10},
    '{5'h08, IDX_TIMING_STATUS, 8'h01, 8'h01, 8'h01},
    '{5'h04, IDX_TIMING_STATUS, 8'h20, 8'h20, 8'h20},
    '{5'h02, IDX_TIMING_STATUS, 8'h08, 8'h08, 8'h08},
    '{5'h01, IDX_TIMING_STATUS, 8'h02, 8'h02, 8'h02}};
  always #12.5 hclk = ~hclk;
  easim_line_model easim_line_model_i (.ones(ones), .tx_run(tx_run),
    .rx_line_clock(rxc), .rx_positive_data(rxp), .rx_negative_data(rxn),
    .transmit_line_clock(txc));
  easim_top #(.SEC_PERIOD_BITS(SECB), .FAST_PERIOD_BITS(FASTB)) easim_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .rx_line_clock(rxc), .rx_positive_data(rxp), .rx_negative_data(rxn),
    .transmit_line_clock(txc), .rx_in_sync(rx_in_sync), .rx_mf_start(1'b0),
    .rx_slip_event(ev[4]), .tx_slip_event(ev[3]), .tx_mf_boundary(ev[2]),
    .tx_align_frame_start(ev[1]), .crc4_enable(1'b1),
    .rx_crc_mf_boundary(ev[0]), .peer_irq_active(peer),
    .tx_clock_lost_pin(lost_pin), .framer_irq_active(act), .int_n(int_n));
  task automatic tally_and_finish();
    if (fail_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rdv = hrdata[7:0];
  endtask
  task automatic chk(input logic [7:0] idx, input logic [7:0] msk,
                     input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    cmp8(rdv & msk, exp);
  endtask
  task automatic bits(input int n);
    repeat (n * BITC) @(posedge hclk);
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(IDX_RX_ALARM_STATUS, 8'hFF, 8'h01);
    chk(IDX_TIMING_IRQ_MASK, 8'hFF, MASK_RST);
    cmp8({7'h0, int_n}, 8'h01);
    bus(1'b1, IDX_RX_ALARM_STATUS, 8'h01);
    chk(IDX_RX_ALARM_STATUS, 8'h01, 8'h01);
    rx_in_sync <= 1'b1;
    repeat (4) @(posedge hclk);
    bus(1'b1, IDX_RX_ALARM_STATUS, 8'h01);
    chk(IDX_RX_ALARM_STATUS, 8'h01, 8'h00);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].idx, rows[i].wd);
      if (rows[i].ev != 5'h00) begin
        ev <= rows[i].ev;
        @(posedge hclk);
        ev <= 5'h00;
        @(posedge hclk);
      end
      chk(rows[i].idx, rows[i].msk, rows[i].exp);
    end
    chk(IDX_RX_ALARM_STATUS, 8'h10, 8'h10);
    bus(1'b1, IDX_TIMING_IRQ_MASK, 8'h00);
    bus(1'b1, IDX_RX_ALARM_IRQ_MASK, 8'h02);
    ones <= 1'b0;
    bits(250);
    chk(IDX_RX_ALARM_STATUS, 8'h02, 8'h00);
    cmp8({7'h0, int_n}, 8'h01);
    bits(12);
    chk(IDX_RX_ALARM_STATUS, 8'h02, 8'h02);
    cmp8({6'h0, act}, 8'h01);
    cmp8({7'h0, int_n}, 8'h00);
    bus(1'b1, IDX_RX_ALARM_IRQ_MASK, 8'h00);
    repeat (3) @(posedge hclk);
    cmp8({7'h0, int_n}, 8'h01);
    ones <= 1'b1;
    bits(1100);
    bus(1'b1, IDX_RX_ALARM_STATUS, 8'h0A);
    chk(IDX_RX_ALARM_STATUS, 8'h0A, 8'h08);
    ones <= 1'b0;
    bits(1100);
    bus(1'b1, IDX_RX_ALARM_STATUS, 8'h0A);
    chk(IDX_RX_ALARM_STATUS, 8'h0A, 8'h02);
    tx_run <= 1'b0;
    bits(12);
    chk(IDX_TIMING_STATUS, 8'h04, 8'h04);
    cmp8({7'h0, lost_pin}, 8'h01);
    bus(1'b1, IDX_CONTROL, 8'h80);
    // The pin is registered one edge after the control write lands.
    repeat (2) @(posedge hclk);
    cmp8({7'h0, lost_pin}, 8'h00);
    tx_run <= 1'b1;
    bus(1'b1, IDX_TIMING_IRQ_MASK, 8'h10);
    bus(1'b1, IDX_TIMING_STATUS, 8'h10);
    bits(FASTB + 4);
    chk(IDX_TIMING_STATUS, 8'h10, 8'h10);
    cmp8({6'h0, act}, 8'h02);
    bus(1'b1, IDX_CONTROL, 8'h00);
    bus(1'b1, IDX_TIMING_STATUS, 8'h10);
    bits(20);
    chk(IDX_TIMING_STATUS, 8'h10, 8'h00);
    bits(50);
    chk(IDX_TIMING_STATUS, 8'h10, 8'h10);
    bus(1'b1, IDX_TIMING_IRQ_MASK, 8'h00);
    peer <= 6'h2A;
    repeat (4) @(posedge hclk);
    cmp8({7'h0, int_n}, 8'h00);
    chk(IDX_FRAMER_IRQ_SUMMARY, 8'hFF, 8'hA8);
    peer <= 6'h00;
    repeat (4) @(posedge hclk);
    cmp8({7'h0, int_n}, 8'h01);
    tally_and_finish();
  end
  // The tests need about 21000 cycles; this limit leaves ample margin.
  initial begin
    repeat (60000) @(posedge hclk);
    fail_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
